// file: entry_trace_pkg.sv
package entry_trace_pkg;
    localparam int PC_W = 24;
    localparam int WORD_W = 16;
    localparam int VEC_W = 7;
    localparam int VEC_COUNT = 71;
    localparam logic [PC_W-1:0] VEC_TABLE_END = 24'h00011b;
    // table layout, in entries
    localparam logic [VEC_W-1:0] EXC_BASE = 7'h00;
    localparam logic [VEC_W-1:0] TRAP_BASE = 7'h10;
    localparam logic [VEC_W-1:0] EVENT_BASE = 7'h20;
    localparam logic [VEC_W-1:0] SWI_BASE = 7'h40;
    // six bound exception entries; 7'h06 to 7'h0f stay unused
    localparam logic [VEC_W-1:0] EXC_RESET = 7'h00;
    localparam logic [VEC_W-1:0] EXC_BREAK = 7'h01;
    localparam logic [VEC_W-1:0] EXC_TRACE = 7'h02;
    localparam logic [VEC_W-1:0] EXC_STACK = 7'h03;
    localparam logic [VEC_W-1:0] EXC_DIVIDE = 7'h04;
    localparam logic [VEC_W-1:0] EXC_USER_RET = 7'h05;
    localparam logic [VEC_W-1:0] EXC_LAST_USED = 7'h05;
    // program_status_word fields
    localparam int PSW_SM_BIT = 15;
    localparam int STATUS_SINGLE_STEP_BIT_BIT = 14;
    localparam logic [WORD_W-1:0] PSW_USER_LOCK = 16'hcf00;
    localparam logic [WORD_W-1:0] PSW_RESET_VAL = 16'h8000;
    localparam logic [WORD_W-1:0] SSP_RESET_VAL = 16'h0100;
    localparam logic [WORD_W-1:0] WORD_BYTES = 16'h0002;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    // frame word index, in push order
    localparam logic [1:0] FW_LOW = 2'h0;
    localparam logic [1:0] FW_HIGH = 2'h1;
    localparam logic [1:0] FW_PSW = 2'h2;
    typedef enum logic [4:0]
    {
        st_idle  = 5'h01,
        st_exec  = 5'h02,
        st_next  = 5'h04,
        st_push  = 5'h08,
        st_fetch = 5'h10
    } seq_state_type;
endpackage

// file: interrupt_entry_trace_unit.sv
// Notes on behaviour
// RL1 - every frame goes on system stack
// RL2 - reset reloads stack pointer, builds no frame
// RL3 - push low pc, padded high byte, status
// RL4 - page zero mode omits high address word
// RL5 - frame: one or two pc words, one status
// RL6 - vectors live below code address 11b hex
// RL7 - entry gives routine address and new status
// RL8 - software keeps routines word aligned, low 64k
// RL9 - new status sets mode, bank, priority
// RL10 - exceptions, traps, events, software interrupts in order
// RL11 - six exception vectors used, ten reserved
// RL12 - single step raises trace after each instruction
// RL13 - step flag sampled at instruction start
// RL14 - invalid instructions skipped, never traced
// RL15 - user mode return gives exception, no trace
// RL16 - user mode return raises exception interrupt
// RL17 - trace first, then pending interrupt
// RL18 - reset aborts at any step
// RL19 - instruction setting the flag is untraced
// RL20 - trap, then trace, then event interrupt
// RL21 - step flag writable only in system mode
// RL22 - return restores flag from stacked status
// RL23 - entry n read at four n, address first
// RL24 - trace frame returns to following instruction
`timescale 1ns/1ps
module interrupt_entry_trace_unit
    import entry_trace_pkg::*;
#(
    parameter int              VEC_N    = VEC_COUNT,
    parameter logic [WORD_W-1:0] SSP_INIT = SSP_RESET_VAL
)
(
    input  wire logic              clk,              // core clock
    input  wire logic              rst,              // async reset, high
    input  wire logic              page_zero_select, // 16-bit address mode
    input  wire logic              ins_go,           // instruction cycle starts
    input  wire logic              ins_defined,      // opcode is defined
    input  wire logic              ins_allowed,      // operation allowed in mode
    input  wire logic              ins_is_return,    // return_from_interrupt op
    input  wire logic              ins_is_trap,      // trap instruction
    input  wire logic [3:0]        ins_trap_num,     // trap number
    input  wire logic [PC_W-1:0]   next_pc,          // address of next instruction
    output logic                   exec_go,          // execute now, pulse
    input  wire logic              exec_done,        // execution finished, pulse
    input  wire logic              psw_wr,           // software status write
    input  wire logic [WORD_W-1:0] psw_wr_data,      // written status
    input  wire logic              psw_ret_load,     // return restores status
    input  wire logic [WORD_W-1:0] psw_ret_data,     // status popped from frame
    input  wire logic              irq_req,          // arbitrated interrupt pending
    input  wire logic [VEC_W-1:0]  irq_vec,          // its vector number
    output logic                   irq_ack,          // interrupt taken, pulse
    output logic                   ins_done,         // sequence complete, pulse
    output logic                   pc_load,          // jump to pc_new, pulse
    output logic [PC_W-1:0]        pc_new,           // service routine address
    output logic [WORD_W-1:0]      program_status_word, // current status
    output logic [WORD_W-1:0]      sys_stack_ptr,    // system stack pointer
    output logic                   code_rd,          // code read request
    output logic [PC_W-1:0]        code_addr,        // code byte address
    input  wire logic [WORD_W-1:0] code_rdata,       // code word
    input  wire logic              code_ack,         // code read done
    output logic                   stack_wr,         // stack write request
    output logic [WORD_W-1:0]      stack_addr,       // stack byte address
    output logic [WORD_W-1:0]      stack_wdata,      // stack word
    input  wire logic              stack_ack         // stack write done
);

    generate
        if (VEC_N < 1 || VEC_N > VEC_COUNT)
        begin : g_bad_vec
            $error("vector count out of range");
        end
    endgenerate

    seq_state_type     state_r;
    logic              tm_latched_r;
    logic              trap_r;
    logic [3:0]        trap_num_r;
    logic              chain_r;
    logic [VEC_W-1:0]  vec_r;
    logic [1:0]        fw_r;
    logic              fv_r;
    logic [PC_W-1:0]   ret_addr_r;
    logic [PC_W-1:0]   pc_new_r;
    logic [WORD_W-1:0] psw_r;
    logic [WORD_W-1:0] ssp_r;
    logic              exec_go_r;
    logic              irq_ack_r;
    logic              ins_done_r;
    logic              pc_load_r;
    logic              code_rd_r;
    logic [PC_W-1:0]   code_addr_r;
    logic              stack_wr_r;
    logic [WORD_W-1:0] stack_addr_r;
    logic [WORD_W-1:0] stack_wdata_r;
    logic              user_mode;
    logic              irq_ok;
    logic              push_ack;
    logic              fetch_ack;

    // entry n holds its address word at 4n and status word at 4n+2
    function automatic logic [PC_W-1:0] vec_addr(input logic [VEC_W-1:0] v,
                                                 input logic second);
        vec_addr = {{(PC_W-VEC_W-2){1'b0}}, v, second, 1'b0}; // see RL23
    endfunction

    function automatic logic [WORD_W-1:0] frame_word(input logic [1:0] idx,
                                                     input logic [PC_W-1:0] ra,
                                                     input logic [WORD_W-1:0] ps);
        unique case (idx)
            FW_LOW:  frame_word = ra[WORD_W-1:0];              // see RL3
            FW_HIGH: frame_word = {PAD_BYTE, ra[PC_W-1:WORD_W]}; // see RL3
            default: frame_word = ps;                          // see RL5
        endcase
    endfunction

    assign user_mode = ~psw_r[PSW_SM_BIT];
    // an interrupt vector number past the table is never taken
    assign irq_ok    = irq_req && (irq_vec < VEC_W'(VEC_N))             // see RL6
                       && !((irq_vec > EXC_LAST_USED) && (irq_vec < TRAP_BASE)); // see RL11
    assign push_ack  = (state_r == st_push) && stack_wr_r && stack_ack;
    assign fetch_ack = (state_r == st_fetch) && code_rd_r && code_ack;

    // instruction sequencer; reset aborts anywhere and restarts at reset entry
    always_ff @(posedge clk or posedge rst)                  // see RL18
    begin
        if (rst)
        begin
            state_r      <= st_fetch;                        // see RL2
            vec_r        <= EXC_RESET;
            fv_r         <= 1'b0;
            fw_r         <= FW_LOW;
            chain_r      <= 1'b0;
            tm_latched_r <= 1'b0;
            trap_r       <= 1'b0;
            trap_num_r   <= '0;
            ret_addr_r   <= '0;
            pc_new_r     <= '0;
            exec_go_r    <= 1'b0;
            irq_ack_r    <= 1'b0;
            ins_done_r   <= 1'b0;
            pc_load_r    <= 1'b0;
            code_rd_r    <= 1'b0;
            code_addr_r  <= '0;
            stack_wr_r   <= 1'b0;
            stack_addr_r <= '0;
            stack_wdata_r <= '0;
        end
        else
        begin
            exec_go_r  <= 1'b0;
            irq_ack_r  <= 1'b0;
            ins_done_r <= 1'b0;
            pc_load_r  <= 1'b0;
            unique case (state_r)
                st_idle:
                begin
                    if (ins_go)
                    begin
                        tm_latched_r <= psw_r[STATUS_SINGLE_STEP_BIT_BIT];   // see RL13, RL19
                        trap_r       <= ins_is_trap;
                        trap_num_r   <= ins_trap_num;
                        if (!(ins_defined && ins_allowed))
                        begin
                            ins_done_r <= 1'b1;              // see RL14
                        end
                        else if (ins_is_return && user_mode)
                        begin
                            // not executed, so never traced
                            ret_addr_r <= next_pc;
                            vec_r      <= EXC_USER_RET;      // see RL15, RL16
                            chain_r    <= 1'b0;
                            fw_r       <= FW_LOW;
                            state_r    <= st_push;
                        end
                        else
                        begin
                            exec_go_r <= 1'b1;
                            state_r   <= st_exec;
                        end
                    end
                end
                st_exec:
                begin
                    if (exec_done)
                    begin
                        ret_addr_r <= next_pc;               // see RL24
                        state_r    <= st_next;
                    end
                end
                st_next:
                begin
                    fw_r    <= FW_LOW;
                    chain_r <= 1'b1;
                    if (trap_r)
                    begin
                        trap_r  <= 1'b0;
                        vec_r   <= TRAP_BASE + {3'h0, trap_num_r}; // see RL10, RL20
                        state_r <= st_push;
                    end
                    else if (tm_latched_r)
                    begin
                        tm_latched_r <= 1'b0;
                        vec_r        <= EXC_TRACE;          // see RL12, RL17
                        state_r      <= st_push;
                    end
                    else if (irq_ok)
                    begin
                        irq_ack_r <= 1'b1;                  // see RL17, RL20
                        vec_r     <= irq_vec;
                        state_r   <= st_push;
                    end
                    else
                    begin
                        ins_done_r <= 1'b1;
                        state_r    <= st_idle;
                    end
                end
                st_push:
                begin
                    if (!stack_wr_r)
                    begin
                        stack_wr_r    <= 1'b1;
                        stack_addr_r  <= ssp_r - WORD_BYTES; // see RL1
                        stack_wdata_r <= frame_word(fw_r, ret_addr_r, psw_r);
                    end
                    else if (stack_ack)
                    begin
                        stack_wr_r <= 1'b0;
                        if (fw_r == FW_PSW)
                        begin
                            fv_r    <= 1'b0;
                            state_r <= st_fetch;
                        end
                        else if (fw_r == FW_LOW && page_zero_select)
                        begin
                            fw_r <= FW_PSW;                  // see RL4, RL5
                        end
                        else
                        begin
                            fw_r <= fw_r + 2'h1;             // see RL3
                        end
                    end
                end
                st_fetch:
                begin
                    if (!code_rd_r)
                    begin
                        code_rd_r   <= 1'b1;
                        code_addr_r <= vec_addr(vec_r, fv_r); // see RL6, RL23
                    end
                    else if (code_ack)
                    begin
                        code_rd_r <= 1'b0;
                        if (!fv_r)
                        begin
                            // only 16 address bits exist in a vector
                            pc_new_r <= {PAD_BYTE, code_rdata}; // see RL7
                            fv_r     <= 1'b1;
                        end
                        else
                        begin
                            pc_load_r  <= 1'b1;
                            ret_addr_r <= pc_new_r;          // see RL20
                            state_r    <= chain_r ? st_next : st_idle;
                            ins_done_r <= ~chain_r;
                        end
                    end
                end
            endcase
        end
    end

    // status word: vector load, frame restore, then software write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            psw_r <= PSW_RESET_VAL;
        end
        else if (fetch_ack && fv_r)
        begin
            psw_r <= code_rdata;                             // see RL7, RL9
        end
        else if (psw_ret_load)
        begin
            psw_r <= psw_ret_data;                           // see RL22
        end
        else if (psw_wr)
        begin
            // user code cannot touch mode, step flag or priority
            psw_r <= user_mode ? ((psw_r & PSW_USER_LOCK) | (psw_wr_data & ~PSW_USER_LOCK))
                               : psw_wr_data;                // see RL21
        end
    end

    // system stack pointer; a reset frees any frame in flight
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ssp_r <= SSP_INIT;                               // see RL2
        end
        else if (push_ack)
        begin
            ssp_r <= ssp_r - WORD_BYTES;                     // see RL1
        end
    end

    assign exec_go             = exec_go_r;
    assign irq_ack             = irq_ack_r;
    assign ins_done            = ins_done_r;
    assign pc_load             = pc_load_r;
    assign pc_new              = pc_new_r;
    assign program_status_word = psw_r;
    assign sys_stack_ptr       = ssp_r;
    assign code_rd             = code_rd_r;
    assign code_addr           = code_addr_r;
    assign stack_wr            = stack_wr_r;
    assign stack_addr          = stack_addr_r;
    assign stack_wdata         = stack_wdata_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_invalid_skip;
        (state_r == st_idle) && ins_go && !(ins_defined && ins_allowed)
            |=> ins_done_r && (state_r == st_idle) && !exec_go_r ##1 !code_rd_r;
    endproperty
    a_invalid_skip: assert property (p_invalid_skip) else $error("invalid op not skipped"); // see RL14

    property p_user_return;
        (state_r == st_idle) && ins_go && ins_defined && ins_allowed && ins_is_return
            && user_mode |=> (state_r == st_push) && (vec_r == EXC_USER_RET) && !exec_go_r;
    endproperty
    a_user_return: assert property (p_user_return) else $error("user return not trapped"); // see RL15

    property p_trace_first;
        (state_r == st_exec) && exec_done && tm_latched_r && !trap_r
            |=> ##1 (state_r == st_push) && (vec_r == EXC_TRACE);
    endproperty
    a_trace_first: assert property (p_trace_first) else $error("trace not taken first"); // see RL17

    property p_trap_before_trace;
        (state_r == st_exec) && exec_done && tm_latched_r && trap_r
            |=> ##1 (vec_r == TRAP_BASE + {3'h0, trap_num_r}) && tm_latched_r && !irq_ack_r;
    endproperty
    a_trap_before_trace: assert property (p_trap_before_trace) else $error("trap order wrong"); // see RL20

    property p_flag_sampled;
        (state_r == st_idle) && ins_go |=> tm_latched_r == $past(psw_r[STATUS_SINGLE_STEP_BIT_BIT]);
    endproperty
    a_flag_sampled: assert property (p_flag_sampled) else $error("step flag not sampled"); // see RL13

    property p_page_zero_skip;
        push_ack && page_zero_select && (fw_r == FW_LOW) |=> (fw_r == FW_PSW) ##1 stack_wr_r;
    endproperty
    a_page_zero_skip: assert property (p_page_zero_skip) else $error("high word not omitted"); // see RL4

    property p_high_word;
        stack_wr_r && (fw_r == FW_HIGH) |-> stack_wdata_r == {PAD_BYTE, ret_addr_r[PC_W-1:WORD_W]};
    endproperty
    a_high_word: assert property (p_high_word) else $error("high frame word wrong"); // see RL3

    property p_vec_addr;
        code_rd_r && (state_r == st_fetch) |-> (code_addr_r == {vec_r, fv_r, 1'b0})
            && (code_addr_r <= VEC_TABLE_END);
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // see RL23

    property p_no_reserved;
        code_rd_r && (state_r == st_fetch) |-> !((vec_r > EXC_LAST_USED) && (vec_r < TRAP_BASE));
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved vector"); // see RL11

    property p_ssp_step;
        push_ack |=> ssp_r == $past(ssp_r) - WORD_BYTES;
    endproperty
    a_ssp_step: assert property (p_ssp_step) else $error("stack pointer not stepped"); // see RL1

    property p_user_lock;
        psw_wr && user_mode && !psw_ret_load && !fetch_ack
            |=> psw_r[STATUS_SINGLE_STEP_BIT_BIT] == $past(psw_r[STATUS_SINGLE_STEP_BIT_BIT]) && !psw_r[PSW_SM_BIT];
    endproperty
    a_user_lock: assert property (p_user_lock) else $error("user changed step flag"); // see RL21

    property p_status_load;
        fetch_ack && fv_r |=> pc_load_r && (psw_r == $past(code_rdata));
    endproperty
    a_status_load: assert property (p_status_load) else $error("status not replaced"); // see RL9

    c_trace_entry: cover property ((state_r == st_push) && (vec_r == EXC_TRACE) ##[1:40] pc_load_r);
    c_trap_trace_irq: cover property (trap_r && tm_latched_r ##[1:200] irq_ack_r);
    c_page_zero_frame: cover property (push_ack && page_zero_select);
    c_user_return: cover property ((vec_r == EXC_USER_RET) && pc_load_r);

endmodule

// file: mem_model.sv
`timescale 1ns/1ps
module mem_model
(
    input  wire logic        clk,         // core clock
    input  wire logic        slow,        // stretch every answer by three cycles
    input  wire logic        code_rd,     // code read request
    input  wire logic [23:0] code_addr,   // code byte address
    output logic      [15:0] code_rdata,  // code word
    output logic             code_ack,    // code read done
    input  wire logic        stack_wr,    // stack write request
    input  wire logic [15:0] stack_addr,  // stack byte address
    input  wire logic [15:0] stack_wdata, // stack word
    output logic             stack_ack    // stack write done
);
    logic [15:0] stk [logic [15:0]];
    int          nwr = 0;
    logic [1:0]  cw  = 2'h0;
    logic [1:0]  sw  = 2'h0;

    initial
    begin
        code_rdata = 16'h5a5a;
        code_ack = 1'b0;
        stack_ack = 1'b0;
    end

    // data outside the ack cycle toggles so a late sample never looks valid
    always @(posedge clk)
    begin
        code_ack <= 1'b0;
        code_rdata <= ~code_rdata;
        if (!code_rd || code_ack)
            cw <= slow ? 2'h3 : 2'h0;
        else if (cw != 2'h0)
            cw <= cw - 2'h1;
        else
        begin
            code_ack <= 1'b1;
            // routines kept word aligned in the low 64k, status keeps system mode
            code_rdata <= code_addr[1] ? (16'h8000 | code_addr[15:0])
                                       : (16'h2000 + code_addr[15:0]);
        end
    end

    always @(posedge clk)
    begin
        stack_ack <= 1'b0;
        if (!stack_wr || stack_ack)
            sw <= slow ? 2'h3 : 2'h0;
        else if (sw != 2'h0)
            sw <= sw - 2'h1;
        else
        begin
            stack_ack <= 1'b1;
            stk[stack_addr] = stack_wdata;
            nwr++;
        end
    end
endmodule

// file: tb_interrupt_entry_trace_unit.sv
`timescale 1ns/1ps
module tb_interrupt_entry_trace_unit
    import entry_trace_pkg::*;
;
    logic              clk = 1'b0, rst = 1'b1, page_zero_select = 1'b0, ins_go = 1'b0;
    logic              ins_defined = 1'b0, ins_allowed = 1'b0, ins_is_return = 1'b0;
    logic              ins_is_trap = 1'b0, exec_done = 1'b0, psw_wr = 1'b0, psw_ret_load = 1'b0;
    logic              irq_req = 1'b0, slow = 1'b0, pw_go = 1'b0;
    logic [3:0]        ins_trap_num = 4'h0;
    logic [VEC_W-1:0]  irq_vec = 7'h00;
    logic [PC_W-1:0]   next_pc = 24'h000000;
    logic [WORD_W-1:0] psw_wr_data = 16'h0000, psw_ret_data = 16'h0000;
    logic              exec_go, irq_ack, ins_done, pc_load, code_rd, code_ack, stack_wr, stack_ack;
    logic [PC_W-1:0]   pc_new, code_addr;
    logic [WORD_W-1:0] program_status_word, sys_stack_ptr, code_rdata, stack_addr, stack_wdata;
    int                bad_count = 0;
    int                checked = 0;
    logic [15:0]       lq[$];
    logic [15:0]       sp;

    interrupt_entry_trace_unit interrupt_entry_trace_unit_inst (.clk, .rst, .page_zero_select,
        .ins_go, .ins_defined, .ins_allowed, .ins_is_return, .ins_is_trap, .ins_trap_num, .next_pc,
        .exec_go, .exec_done, .psw_wr, .psw_wr_data, .psw_ret_load, .psw_ret_data, .irq_req,
        .irq_vec, .irq_ack, .ins_done, .pc_load, .pc_new, .program_status_word, .sys_stack_ptr,
        .code_rd, .code_addr, .code_rdata, .code_ack, .stack_wr, .stack_addr, .stack_wdata,
        .stack_ack);
    mem_model mem_model_inst (.clk, .slow, .code_rd, .code_addr, .code_rdata, .code_ack,
        .stack_wr, .stack_addr, .stack_wdata, .stack_ack);

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // logged mid-cycle so the jump that ends a sequence is queued before it is checked
    always @(negedge clk) if (pc_load === 1'b1) lq.push_back(pc_new[15:0]);
    // the arbiter would withdraw a request once it is taken
    always @(posedge clk) if (irq_ack === 1'b1) irq_req <= 1'b0;

    function automatic logic [15:0] rt(input int n);
        return 16'h2000 + 16'(4 * n);
    endfunction
    function automatic logic [15:0] ps(input int n);
        return 16'h8000 | 16'(4 * n + 2);
    endfunction

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (exec_go === 1'b1)
            begin
                @(posedge clk);
                exec_done <= 1'b1;
                psw_wr <= pw_go;
                @(posedge clk);
                exec_done <= 1'b0;
                psw_wr <= 1'b0;
            end
        end
        while (ins_done !== 1'b1 && n < 500);
        #1;
        chk(24'(n < 500), 24'h1);
    endtask

    task automatic instr(input logic [3:0] kind, input logic [3:0] tn, input logic [23:0] pc);
        @(posedge clk);
        {ins_defined, ins_allowed, ins_is_return, ins_is_trap} <= kind;
        ins_trap_num <= tn;
        next_pc <= pc;
        ins_go <= 1'b1;
        @(posedge clk);
        ins_go <= 1'b0;
        wait_done();
    endtask

    task automatic setpsw(input logic [15:0] v);
        @(posedge clk);
        psw_wr <= 1'b1;
        psw_wr_data <= v;
        @(posedge clk);
        psw_wr <= 1'b0;
    endtask

    // frame words are read back downward from the expected stack pointer
    task automatic frame(input logic [15:0] lo, input logic [7:0] hi, input logic [15:0] p);
        sp = sp - 16'h2;
        chk(mem_model_inst.stk[sp], lo);
        if (page_zero_select === 1'b0)
        begin
            sp = sp - 16'h2;
            chk(mem_model_inst.stk[sp], {8'h00, hi});
        end
        sp = sp - 16'h2;
        chk(mem_model_inst.stk[sp], p);
    endtask

    task automatic fin(input int t);
        $display("test %0d done", t);
    endtask

    initial
    begin
        #20000;
        bad_count++;
        summarize();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wait_done();
        sp = SSP_RESET_VAL;
        chk(pc_new, {8'h00, rt(0)});
        chk(program_status_word, ps(0));
        chk(sys_stack_ptr, sp);
        chk(24'(mem_model_inst.nwr), 24'h0);
        instr(4'b1100, 4'h0, 24'h000100);
        chk(24'(lq.size()), 24'h1);
        fin(1);
        @(posedge clk);
        slow <= 1'b1;
        instr(4'b1101, 4'h5, 24'h123456);
        frame(16'h3456, 8'h12, ps(0));
        chk(sys_stack_ptr, sp);
        chk(pc_new, {8'h00, rt(21)});
        chk(program_status_word, ps(21));
        fin(2);
        @(posedge clk);
        slow <= 1'b0;
        psw_wr_data <= 16'hc000;
        pw_go = 1'b1;
        instr(4'b1100, 4'h0, 24'h000200);
        pw_go = 1'b0;
        chk(24'(lq.size()), 24'h2);
        chk(program_status_word, 16'hc000);
        instr(4'b1100, 4'h0, 24'h000204);
        frame(16'h0204, 8'h00, 16'hc000);
        chk(lq[$], rt(2));
        chk(program_status_word, ps(2));
        fin(3);
        setpsw(16'hc000);
        for (int i = 0; i < 2; i++)
            instr(i ? 4'b1000 : 4'b0100, 4'h0, 24'h000300);
        chk(sys_stack_ptr, sp);
        chk(24'(lq.size()), 24'h3);
        setpsw(16'h4000);
        instr(4'b1110, 4'h0, 24'h000088);
        frame(16'h0088, 8'h00, 16'h4000);
        chk(lq[$], rt(5));
        chk(24'(lq.size()), 24'h4);
        fin(4);
        setpsw(16'h0000);
        setpsw(16'hffff);
        @(negedge clk);
        chk(program_status_word, 16'h30ff);
        @(posedge clk);
        psw_ret_load <= 1'b1;
        psw_ret_data <= 16'hc123;
        @(posedge clk);
        psw_ret_load <= 1'b0;
        @(negedge clk);
        chk(program_status_word, 16'hc123);
        @(posedge clk);
        irq_vec <= 7'h25;
        irq_req <= 1'b1;
        instr(4'b1101, 4'h3, 24'h010200);
        frame(16'h0200, 8'h01, 16'hc123);
        frame(rt(19), 8'h00, ps(19));
        frame(rt(2), 8'h00, ps(2));
        chk(lq[$-2], rt(19));
        chk(lq[$-1], rt(2));
        chk(lq[$], rt(37));
        fin(5);
        @(posedge clk);
        page_zero_select <= 1'b1;
        irq_vec <= 7'h46;
        irq_req <= 1'b1;
        instr(4'b1101, 4'hf, 24'h000456);
        frame(16'h0456, 8'h00, ps(37));
        frame(rt(31), 8'h00, ps(31));
        chk(sys_stack_ptr, sp);
        chk(lq[$], rt(70));
        fin(6);
        @(posedge clk);
        page_zero_select <= 1'b0;
        ins_go <= 1'b1;
        @(posedge clk);
        ins_go <= 1'b0;
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk(program_status_word, PSW_RESET_VAL);
        chk(sys_stack_ptr, SSP_RESET_VAL);
        chk(24'(stack_wr), 24'h0);
        @(posedge clk);
        rst <= 1'b0;
        wait_done();
        chk(pc_new, {8'h00, rt(0)});
        fin(7);
        summarize();
    end
endmodule
